//--- rtl/baud_tick_gen.sv
module baud_tick_gen (
    input wire logic clock,
    input wire logic reset,
    input wire logic run,
    input wire logic high_speed,
    input wire logic [uart_tx_pkg::DIVIDER_WIDTH-1:0] divider,
    output logic tick
);
    localparam int W = uart_tx_pkg::BAUD_COUNT_WIDTH;

    logic [W-1:0] count_q;
    logic tick_q;

    wire [W-1:0] div_plus_one = W'(divider) + W'(1);
    wire [W-1:0] period_high = div_plus_one << uart_tx_pkg::BAUD_SHIFT_HIGH;
    wire [W-1:0] period_low = div_plus_one << uart_tx_pkg::BAUD_SHIFT_LOW;
    wire [W-1:0] limit = (high_speed ? period_high : period_low) - W'(1);
    wire wrap = (count_q >= limit);

    assign tick = tick_q;

    // restarts with the transmitter so the first bit time is a full one
    always_ff @(posedge clock) begin
        if (reset || !run) begin
            count_q <= '0;
            tick_q <= 1'b0;
        end else begin
            count_q <= wrap ? '0 : count_q + W'(1);
            tick_q <= wrap;
        end
    end
endmodule

//--- rtl/tx_buffer.sv
module tx_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic flush,
    tx_stream_if.sink fill,
    tx_stream_if.src drain
);
    localparam int PTR_W = (DEPTH > 2) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("tx_buffer depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic [WIDTH-1:0] rd_data_q;

    wire push = fill.valid & fill.ready;
    wire pop = drain.valid & drain.ready;
    wire [PTR_W-1:0] rd_next = rd_ptr_q + PTR_W'(pop);

    assign fill.ready = (count_q != CNT_W'(DEPTH));
    assign drain.valid = (count_q != '0);
    assign drain.data = rd_data_q;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= fill.data;
        end
    end

    // read data registered; bypass keeps a word pushed into an empty buffer visible next cycle
    always_ff @(posedge clock) begin
        if (push && (count_q == CNT_W'(pop)) && (wr_ptr_q == rd_next)) begin
            rd_data_q <= fill.data;
        end else begin
            rd_data_q <= mem_q[rd_next];
        end
    end

    always_ff @(posedge clock) begin
        if (reset || flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + PTR_W'(push);
            rd_ptr_q <= rd_next;
            count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule

//--- rtl/uart_tx_frame_and_break.sv
// What this block does
// - word length is 8 bits, or 9 when word_length_select is set
// - parity_type_select picks odd or even parity
// - parity_enable puts a parity bit in the frame or leaves it out
// - one or two stop bits from stop_count_select, whatever the word length
// - parity or address bit is the last word bit; always one start bit
// - in 9-bit mode without parity the ninth bit comes from tx_ninth_bit
// - shift register reloads only after the stop bit, only if data waits
// - frame starts only with enable set, data loaded and a baud tick
// - dropping transmit_enable aborts the frame and releases the pin
// - data leaves least significant bit first
// - empty flag clears only by status access then data write
// - data writes are ignored while the empty flag is low
// - empty flag set when the holding buffer holds no word; drives interrupt
// - a write during a frame waits and goes out when that frame ends
// - a write while idle starts a frame at the next baud tick; the empty flag sets then
// - idle flag sets after stop bits or a break; cleared like empty flag
// - break_request held over divider plus one cycles while idle arms a break
// - break is a start bit, thirteen zero bits, then stop bits
// - software sets then clears break_request; a break raises no interrupt
// - break_request held on still ends the break with stop bits
// - enabled and not sending, the line stays high
// - bit time is 64 or 16 times divider plus one clocks
// - port disable drops enable and break, sets both flags
module uart_tx_frame_and_break #(
    parameter int DATA_WIDTH = uart_tx_pkg::DATA_WIDTH,
    parameter int BUFFER_DEPTH = 2
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic port_enable,
    input wire logic transmit_enable,
    input wire logic word_length_select,
    input wire logic parity_type_select,
    input wire logic parity_enable,
    input wire logic stop_count_select,
    input wire logic tx_ninth_bit,
    input wire logic baud_high_speed,
    input wire logic [uart_tx_pkg::DIVIDER_WIDTH-1:0] divider_value,
    input wire logic break_request,
    input wire logic tx_empty_irq_enable,
    input wire logic status_access,
    input wire logic data_write,
    input wire logic [DATA_WIDTH-1:0] data_in,
    output logic tx_out,
    output logic tx_oe_n,
    output logic tx_empty_flag,
    output logic tx_idle_flag,
    output logic tx_irq
);
    localparam int FW = uart_tx_pkg::FRAME_WIDTH;
    localparam int HW = uart_tx_pkg::HOLD_COUNT_WIDTH;

    generate
        if (DATA_WIDTH != uart_tx_pkg::DATA_WIDTH) begin : g_bad_width
            $error("the frame builder only serves 8-bit data");
        end
    endgenerate

    // parity over the bits that precede it; odd when the type bit is set
    function automatic logic parity_of(input logic [DATA_WIDTH-1:0] bits, input logic odd);
        parity_of = (^bits) ^ odd;
    endfunction

    function automatic logic [FW-1:0] build_word(
        input logic [DATA_WIDTH-1:0] data,
        input logic nine,
        input logic par_en,
        input logic par_odd,
        input logic ninth
    );
        logic [DATA_WIDTH-1:0] low7;
        low7 = {1'b0, data[DATA_WIDTH-2:0]};
        if (nine) begin
            build_word = {par_en ? parity_of(data, par_odd) : ninth, data};
        end else if (par_en) begin
            build_word = {1'b0, parity_of(low7, par_odd), data[DATA_WIDTH-2:0]};
        end else begin
            build_word = {1'b0, data};
        end
    endfunction

    // registers
    uart_tx_pkg::tx_state_e state_q, state_d;
    logic [FW-1:0] shift_q, shift_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [1:0] stop_cnt_q, stop_cnt_d;
    logic tx_q, tx_d;
    logic oe_n_q;
    logic empty_flag_q, empty_flag_d;
    logic idle_flag_q, idle_flag_d;
    logic irq_q;
    logic seq_armed_q;
    logic [HW-1:0] hold_cnt_q;
    logic brk_pending_q;
    logic brk_used_q;

    tx_stream_if #(.WIDTH(DATA_WIDTH)) wr_if ();
    tx_stream_if #(.WIDTH(DATA_WIDTH)) rd_if ();

    // disabling the port masks enable and break; the source bits live outside
    wire tx_run = port_enable & transmit_enable;
    wire brk_req = port_enable & break_request;
    wire tick;

    baud_tick_gen u_baud (
        .clock(clock),
        .reset(reset),
        .run(tx_run),
        .high_speed(baud_high_speed),
        .divider(divider_value),
        .tick(tick)
    );

    tx_buffer #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(BUFFER_DEPTH)
    ) u_hold (
        .clock(clock),
        .reset(reset),
        .flush(!port_enable),
        .fill(wr_if.sink),
        .drain(rd_if.src)
    );

    // write acceptance: needs the status access first and an empty flag
    wire write_take = data_write & seq_armed_q & empty_flag_q & wr_if.ready & port_enable;
    assign wr_if.valid = write_take;
    assign wr_if.data = data_in;

    // frame decode
    wire in_idle = (state_q == uart_tx_pkg::st_idle);
    wire in_stop = (state_q == uart_tx_pkg::st_stop);
    wire stop_last = in_stop & (stop_cnt_q == 2'h1);
    wire load_slot = tick & (in_idle | stop_last);
    wire start_break = load_slot & brk_pending_q;
    wire start_data = load_slot & ~brk_pending_q & rd_if.valid;
    wire frame_done = tick & stop_last;
    assign rd_if.ready = start_data;

    wire [FW-1:0] new_word = build_word(rd_if.data, word_length_select, parity_enable,
                                        parity_type_select, tx_ninth_bit);
    wire [3:0] word_bits = word_length_select ? uart_tx_pkg::WORD_BITS_LONG
                                              : uart_tx_pkg::WORD_BITS_SHORT;
    wire [1:0] stop_bits = stop_count_select ? uart_tx_pkg::STOP_TWO
                                             : uart_tx_pkg::STOP_ONE;

    // break arming: hold time measured in system clocks while idle
    wire [HW-1:0] hold_limit = HW'(divider_value) + HW'(1);
    wire hold_counting = brk_req & idle_flag_q & in_idle;
    wire hold_met = (hold_cnt_q > hold_limit);

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bit_cnt_d = bit_cnt_q;
        stop_cnt_d = stop_cnt_q;
        tx_d = tx_q;
        if (!tx_run) begin
            state_d = uart_tx_pkg::st_idle;
            tx_d = uart_tx_pkg::LINE_IDLE;
            bit_cnt_d = '0;
            stop_cnt_d = '0;
        end else if (tick) begin
            case (state_q)
                uart_tx_pkg::st_start: begin
                    state_d = uart_tx_pkg::st_data;
                    tx_d = shift_q[0];
                    shift_d = shift_q >> 1;
                end
                uart_tx_pkg::st_data: begin
                    if (bit_cnt_q == 4'h1) begin
                        state_d = uart_tx_pkg::st_stop;
                        tx_d = uart_tx_pkg::LINE_IDLE;
                        stop_cnt_d = stop_bits;
                    end else begin
                        tx_d = shift_q[0];
                        shift_d = shift_q >> 1;
                        bit_cnt_d = bit_cnt_q - 4'h1;
                    end
                end
                uart_tx_pkg::st_break: begin
                    if (bit_cnt_q == 4'h1) begin
                        // stop bits follow even if the request is still high
                        state_d = uart_tx_pkg::st_stop;
                        tx_d = uart_tx_pkg::LINE_IDLE;
                        stop_cnt_d = stop_bits;
                    end else begin
                        bit_cnt_d = bit_cnt_q - 4'h1;
                    end
                end
                uart_tx_pkg::st_stop: begin
                    if (stop_cnt_q != 2'h1) begin
                        stop_cnt_d = stop_cnt_q - 2'h1;
                    end else begin
                        state_d = uart_tx_pkg::st_idle;
                        tx_d = uart_tx_pkg::LINE_IDLE;
                    end
                end
                default: begin
                    tx_d = uart_tx_pkg::LINE_IDLE;
                end
            endcase
            if (start_break) begin
                state_d = uart_tx_pkg::st_break;
                tx_d = uart_tx_pkg::LINE_ACTIVE;
                bit_cnt_d = uart_tx_pkg::BREAK_LOW_BITS;
            end else if (start_data) begin
                state_d = uart_tx_pkg::st_start;
                tx_d = uart_tx_pkg::LINE_ACTIVE;
                shift_d = new_word;
                bit_cnt_d = word_bits;
            end
        end
    end

    // flags: a hardware set outranks a same-cycle clear
    wire empty_set = ~rd_if.valid & ~wr_if.valid;
    wire idle_set = frame_done;

    always_comb begin
        empty_flag_d = empty_flag_q;
        idle_flag_d = idle_flag_q;
        if (write_take) begin
            empty_flag_d = 1'b0;
            idle_flag_d = 1'b0;
        end
        if (empty_set || !port_enable) begin
            empty_flag_d = 1'b1;
        end
        if (idle_set || !port_enable) begin
            idle_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= uart_tx_pkg::st_idle;
            shift_q <= '0;
            bit_cnt_q <= '0;
            stop_cnt_q <= '0;
            tx_q <= uart_tx_pkg::LINE_IDLE;
            oe_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            stop_cnt_q <= stop_cnt_d;
            tx_q <= tx_d;
            oe_n_q <= ~tx_run;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            empty_flag_q <= uart_tx_pkg::FLAG_RESET_VALUE;
            idle_flag_q <= uart_tx_pkg::FLAG_RESET_VALUE;
            irq_q <= 1'b0;
            seq_armed_q <= 1'b0;
        end else begin
            empty_flag_q <= empty_flag_d;
            idle_flag_q <= idle_flag_d;
            // break frames never touch the empty flag, so they raise nothing here
            irq_q <= empty_flag_d & tx_empty_irq_enable & port_enable;
            seq_armed_q <= port_enable & (status_access | (seq_armed_q & ~data_write));
        end
    end

    // one break per request: the request must fall before another can arm
    always_ff @(posedge clock) begin
        if (reset) begin
            hold_cnt_q <= '0;
            brk_pending_q <= 1'b0;
            brk_used_q <= 1'b0;
        end else begin
            if (!hold_counting) begin
                hold_cnt_q <= '0;
            end else if (!hold_met) begin
                hold_cnt_q <= hold_cnt_q + HW'(1);
            end
            if (!brk_req || !tx_run) begin
                brk_pending_q <= 1'b0;
            end else if (start_break) begin
                brk_pending_q <= 1'b0;
            end else if (hold_met && !brk_used_q) begin
                brk_pending_q <= 1'b1;
            end
            if (!brk_req) begin
                brk_used_q <= 1'b0;
            end else if (start_break) begin
                brk_used_q <= 1'b1;
            end
        end
    end

    assign tx_out = tx_q;
    assign tx_oe_n = oe_n_q;
    assign tx_empty_flag = empty_flag_q;
    assign tx_idle_flag = idle_flag_q;
    assign tx_irq = irq_q;
endmodule

//--- shared/tx_stream_if.sv
interface tx_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport sink (input data, input valid, output ready);
endinterface

//--- shared/uart_tx_pkg.sv
package uart_tx_pkg;

    // system clock rate; one high-speed clock period is one cycle of it
    localparam int CLOCK_HZ = 25_000_000;

    localparam int DATA_WIDTH = 8;
    localparam int FRAME_WIDTH = 9;
    localparam int DIVIDER_WIDTH = 8;

    // baud prescale as a shift: 64 in low-speed mode, 16 in high-speed mode
    localparam int BAUD_SHIFT_LOW = 6;
    localparam int BAUD_SHIFT_HIGH = 4;
    localparam int BAUD_COUNT_WIDTH = DIVIDER_WIDTH + BAUD_SHIFT_LOW + 1;

    // word lengths, bit counter width
    localparam logic [3:0] WORD_BITS_SHORT = 4'h8;
    localparam logic [3:0] WORD_BITS_LONG = 4'h9;

    // break: one start bit plus thirteen zero bits
    localparam logic [3:0] BREAK_ZERO_BITS = 4'hd;
    localparam logic [3:0] BREAK_LOW_BITS = BREAK_ZERO_BITS + 4'h1;

    localparam logic [1:0] STOP_ONE = 2'h1;
    localparam logic [1:0] STOP_TWO = 2'h2;

    localparam logic FLAG_RESET_VALUE = 1'b1;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic LINE_ACTIVE = 1'b0;

    localparam int HOLD_COUNT_WIDTH = DIVIDER_WIDTH + 2;

    typedef enum logic [4:0] {
        st_idle  = 5'b00001,
        st_start = 5'b00010,
        st_data  = 5'b00100,
        st_break = 5'b01000,
        st_stop  = 5'b10000
    } tx_state_e;

endpackage

//--- sim/serial_rx_model.sv
module serial_rx_model (
    input wire logic clock,
    input wire logic line,
    input wire logic [15:0] bit_cycles,
    input wire logic [3:0] nbits,
    input wire logic [1:0] nstop,
    output logic [8:0] word,
    output logic stop_ok,
    output logic [7:0] frames
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] shift;
    logic ok;
    initial begin
        frames = 8'h0;
        word = 9'h0;
        stop_ok = 1'b0;
    end
    // listens only; samples mid-bit so a one-cycle skew at the edges is harmless
    always begin
        @(negedge line);
        repeat (bit_cycles / 2) @(posedge clock);
        shift = 9'h0;
        ok = 1'b1;
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_cycles) @(posedge clock);
            shift[i] = line;
        end
        for (int i = 0; i < nstop; i++) begin
            repeat (bit_cycles) @(posedge clock);
            ok = ok & line;
        end
        word <= shift;
        stop_ok <= ok;
        frames <= frames + 8'h1;
    end
endmodule

//--- sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic port_enable = 1'b1, transmit_enable = 1'b1, tx_empty_irq_enable = 1'b1, baud_high_speed = 1'b1;
    logic word_length_select = 1'b0, parity_type_select = 1'b0, parity_enable = 1'b0, stop_count_select = 1'b0;
    logic tx_ninth_bit = 1'b0, break_request = 1'b0, status_access = 1'b0, data_write = 1'b0;
    logic [7:0] divider_value = 8'h0, data_in = 8'h0, frames, d;
    logic tx_out, tx_oe_n, tx_empty_flag, tx_idle_flag, tx_irq, line, stop_ok;
    logic [8:0] word;
    logic [15:0] bit_cycles;
    int fails = 0, n_tests = 0, low_run = 0, last_low = 0;

    // a released pin floats high through its pull-up
    assign line = tx_oe_n ? 1'b1 : tx_out;
    assign bit_cycles = (baud_high_speed ? 16'h10 : 16'h40) * (16'h1 + 16'(divider_value));

    uart_tx_frame_and_break uart_tx_frame_and_break_inst (.clock, .reset, .port_enable, .transmit_enable,
        .word_length_select, .parity_type_select, .parity_enable, .stop_count_select, .tx_ninth_bit,
        .baud_high_speed, .divider_value, .break_request, .tx_empty_irq_enable, .status_access, .data_write,
        .data_in, .tx_out, .tx_oe_n, .tx_empty_flag, .tx_idle_flag, .tx_irq);
    serial_rx_model serial_rx_model_inst (.clock, .line, .bit_cycles, .nbits(word_length_select ? 4'h9 : 4'h8),
        .nstop(stop_count_select ? 2'h2 : 2'h1), .word, .stop_ok, .frames);

    always #20 clock = ~clock;
    always @(posedge clock) begin
        if (!line) low_run <= low_run + 1;
        else begin
            if (low_run != 0) last_low <= low_run;
            low_run <= 0;
        end
    end

    task check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task send(input logic [7:0] v);
        @(posedge clock) status_access <= 1'b1;
        @(posedge clock) begin
            status_access <= 1'b0;
            data_write <= 1'b1;
            data_in <= v;
        end
        @(posedge clock) data_write <= 1'b0;
    endtask
    // sel: 0 empty flag, 1 idle flag, 2 line low, 3 line high
    task wait_until(input int sel, input int limit);
        int i;
        logic hit;
        for (i = 0; i < limit; i++) begin
            @(posedge clock);
            hit = sel == 0 ? tx_empty_flag : sel == 1 ? tx_idle_flag : sel == 2 ? !line : line;
            if (hit === 1'b1) break;
        end
        if (i == limit) check(32'(sel), 32'hffff);
    endtask
    function logic [8:0] expect_word(input logic [7:0] v);
        logic p;
        p = parity_type_select ^ (word_length_select ? ^v : ^v[6:0]);
        if (!word_length_select) return parity_enable ? {1'b0, p, v[6:0]} : {1'b0, v};
        return parity_enable ? {p, v} : {tx_ninth_bit, v};
    endfunction
    task expect_frame(input logic [8:0] e);
        logic [7:0] c;
        int i;
        c = frames;
        for (i = 0; i < 9000 && frames == c; i++) @(posedge clock);
        check(frames - c, 1);
        check(word, e);
        check(stop_ok, 1'b1);
    endtask

    initial begin
        void'($urandom(50));
        repeat (20) @(posedge clock);
        check({tx_out, tx_oe_n, tx_empty_flag, tx_idle_flag, tx_irq}, 5'h1e);
        reset <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            @(posedge clock);
            {word_length_select, parity_enable, parity_type_select, stop_count_select} <= k[3:0];
            tx_ninth_bit <= 1'($urandom);
            d = 8'($urandom);
            send(d);
            expect_frame(expect_word(d));
            wait_until(1, 2000);
        end
        d = 8'($urandom);
        send(d);
        wait_until(0, 400);
        send(~d);
        send(8'h5a);
        expect_frame(expect_word(d));
        expect_frame(expect_word(~d));
        d = frames;
        repeat (400) @(posedge clock);
        check(frames, d);
        @(posedge clock) data_write <= 1'b1;
        @(posedge clock) data_write <= 1'b0;
        repeat (3) @(posedge clock);
        check(tx_empty_flag, 1'b1);
        repeat (100) @(posedge clock);
        check(frames, d);
        {word_length_select, parity_enable, stop_count_select} <= 3'h0;
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            baud_high_speed <= k[0];
            divider_value <= 8'(1 + k);
            send(8'hff);
            expect_frame(9'h0ff);
            check(last_low, k ? 48 : 128);
            wait_until(1, 4000);
        end
        baud_high_speed <= 1'b1;
        divider_value <= 8'h0;
        send(8'h0f);
        wait_until(2, 500);
        repeat (40) @(posedge clock);
        transmit_enable <= 1'b0;
        repeat (2) @(posedge clock);
        check({tx_out, tx_oe_n}, 2'h3);
        repeat (300) @(posedge clock);
        // data loaded first, enable afterwards
        send(8'h3c);
        repeat (100) @(posedge clock);
        transmit_enable <= 1'b1;
        expect_frame(expect_word(8'h3c));
        wait_until(1, 500);
        send(8'h33);
        repeat (5) @(posedge clock);
        port_enable <= 1'b0;
        repeat (2) @(posedge clock);
        check({tx_empty_flag, tx_idle_flag, tx_oe_n, tx_irq}, 4'he);
        repeat (300) @(posedge clock);
        port_enable <= 1'b1;
        wait_until(1, 500);
        break_request <= 1'b1;
        wait_until(2, 500);
        break_request <= 1'b0;
        wait_until(3, 500);
        repeat (3) @(posedge clock);
        check(last_low, 224);
        check({tx_empty_flag, tx_irq}, 2'h3);
        wait_until(1, 500);
        // request held through the break: stop bits follow and no second break arms
        break_request <= 1'b1;
        wait_until(2, 500);
        wait_until(3, 500);
        repeat (300) @(posedge clock);
        check(last_low, 224);
        check(line, 1'b1);
        tx_empty_irq_enable <= 1'b0;
        break_request <= 1'b0;
        repeat (2) @(posedge clock);
        check(tx_irq, 1'b0);
        tx_empty_irq_enable <= 1'b1;
        wait_until(1, 500);
        d = 8'($urandom);
        send(d);
        expect_frame(expect_word(d));
        summarize();
    end

    // whole run is near 8000 cycles; this cuts a hang at about 100000
    initial begin
        #4_000_000;
        fails++;
        summarize();
    end
endmodule

//--- sim/uart_tx_props.sv
module uart_tx_props (
    input wire logic clock,
    input wire logic reset,
    input wire logic port_enable,
    input wire logic transmit_enable,
    input wire logic baud_high_speed,
    input wire logic [uart_tx_pkg::DIVIDER_WIDTH-1:0] divider_value,
    input wire logic tx_empty_irq_enable,
    input wire logic status_access,
    input wire logic data_write,
    input wire logic tx_out,
    input wire logic tx_oe_n,
    input wire logic tx_empty_flag,
    input wire logic tx_idle_flag,
    input wire logic tx_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic arm_q;
    logic [19:0] low_q;
    logic [19:0] bit_time;
    // only valid while the divider is left alone during a frame
    assign bit_time = (baud_high_speed ? 20'h10 : 20'h40) * (20'h1 + 20'(divider_value));
    always_ff @(posedge clock) begin
        if (reset) begin
            arm_q <= 1'b0;
            low_q <= 20'h0;
        end else begin
            arm_q <= status_access | (arm_q & ~data_write);
            low_q <= tx_out ? 20'h0 : low_q + 20'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence armed_write;
        status_access ##1 (data_write && tx_empty_flag && port_enable);
    endsequence
    sequence unarmed_write;
        data_write && !arm_q && !status_access && tx_empty_flag;
    endsequence
    a_write_clears_flags: assert property (armed_write |=> !tx_empty_flag && !tx_idle_flag)
        else $error("armed data write did not clear the flags");
    a_unarmed_write_ignored: assert property (unarmed_write |=> tx_empty_flag)
        else $error("write without status access was taken");
    a_pin_follows_enable: assert property (!$past(reset) |-> tx_oe_n == !$past(port_enable && transmit_enable))
        else $error("pin enable does not follow port and transmit enable");
    a_released_line_high: assert property (tx_oe_n |-> tx_out)
        else $error("line low while pin released");
    a_abort_releases_pin: assert property ($fell(transmit_enable) |=> tx_oe_n && tx_out)
        else $error("frame not aborted at once");
    a_disable_sets_flags: assert property (!port_enable |=> tx_empty_flag && tx_idle_flag && !tx_irq)
        else $error("port disable did not set the flags");
    a_irq_follows_flag: assert property (!$past(reset) |->
        tx_irq == (tx_empty_flag && $past(tx_empty_irq_enable && port_enable)))
        else $error("interrupt does not follow the empty flag");
    a_low_run_max: assert property (low_q <= 20'he * bit_time)
        else $error("line low longer than a break");
    a_low_run_min: assert property ($rose(tx_out) && !tx_oe_n |-> low_q >= bit_time)
        else $error("low run shorter than one bit time");
    c_break_seen: cover property (low_q == 20'he * bit_time);
endmodule

bind uart_tx_frame_and_break uart_tx_props uart_tx_props_inst (.clock, .reset, .port_enable, .transmit_enable,
    .baud_high_speed, .divider_value, .tx_empty_irq_enable, .status_access, .data_write, .tx_out, .tx_oe_n,
    .tx_empty_flag, .tx_idle_flag, .tx_irq);
